/* File: design/compare_output_unit.sv */
// One compare-output channel: waveform register and pin override.
// Assumes match and TOP strobes are already qualified by the timer tick.
`timescale 1ns/1ps

module compare_output_unit #(
  parameter bit IS_CHAN_A = 1'b1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Configuration
  input wire logic [1:0] output_mode_in,
  input wire logic [3:0] waveform_mode_select_in,
  input wire logic [1:0] family_in,
  input wire logic port_dir_out_in,
  // Events
  input wire logic match_in,
  input wire logic at_top_in,
  input wire logic counting_up_in,
  input wire logic cmp_equals_top_in,
  // Pin
  output logic compare_output_out,
  output logic pin_override_out,
  output logic pin_oe_out
);

  logic wave_reg;
  logic wave_next;
  logic toggle_ok;

  always_comb begin
    toggle_ok = 1'b0;
    if (family_in == timer16_pkg::FAM_NONPWM) begin
      toggle_ok = 1'b1;
    end else if (IS_CHAN_A && family_in == timer16_pkg::FAM_FAST) begin
      toggle_ok = (waveform_mode_select_in[3:1] == 3'h7);
    end else if (IS_CHAN_A && family_in == timer16_pkg::FAM_DUAL) begin
      toggle_ok = (waveform_mode_select_in[3:2] == 2'h2);
    end
  end

  always_comb begin
    wave_next = wave_reg;
    if (output_mode_in == 2'h1) begin
      if (match_in && toggle_ok) begin
        wave_next = ~wave_reg;
      end
    end else if (output_mode_in[1]) begin
      unique case (family_in)
        timer16_pkg::FAM_FAST: begin
          // Equal-to-TOP match ignored; only the TOP action runs
          if (at_top_in) begin
            wave_next = ~output_mode_in[0];
          end else if (match_in && !cmp_equals_top_in) begin
            wave_next = output_mode_in[0];
          end
        end
        timer16_pkg::FAM_DUAL: begin
          if (match_in) begin
            wave_next = counting_up_in ? output_mode_in[0] : ~output_mode_in[0];
          end
        end
        default: begin
          if (match_in) begin
            wave_next = output_mode_in[0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wave_reg <= 1'b0;
    end else begin
      wave_reg <= wave_next;
    end
  end

  assign compare_output_out = wave_reg;
  // Toggle code in a mode that forbids it leaves the pin to the port
  assign pin_override_out = (output_mode_in[1] | (output_mode_in[0] & toggle_ok));
  assign pin_oe_out = pin_override_out & port_dir_out_in;
endmodule

/* File: design/tick_prescaler.sv */
// Timer tick generator: one-cycle enable from the io clock or an external count pin.
// Assumes the count pin is already synchronous to clk_in.
`timescale 1ns/1ps
`include "timer16_regs.svh"

module tick_prescaler (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic [2:0] clock_source_select_in,
  input wire logic ext_count_pin_in,
  // Tick
  output logic timer_tick_enable_out
);

  logic [`PRESCALE_WIDTH-1:0] div_reg;
  logic ext_prev_reg;
  logic tick_next;

  // Free-running divider shared by all ratios
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= ext_count_pin_in;
    end
  end

  always_comb begin
    unique case (clock_source_select_in)
      3'h0: tick_next = 1'b0;
      3'h1: tick_next = 1'b1;
      3'h2: tick_next = (div_reg[2:0] == `DIV_8);
      3'h3: tick_next = (div_reg[5:0] == `DIV_64);
      3'h4: tick_next = (div_reg[7:0] == `DIV_256);
      3'h5: tick_next = (div_reg == `DIV_1024);
      3'h6: tick_next = ext_prev_reg & ~ext_count_pin_in;
      3'h7: tick_next = ~ext_prev_reg & ext_count_pin_in;
    endcase
  end

  assign timer_tick_enable_out = tick_next;
endmodule

/* File: design/timer16_pkg.sv */
// Types shared by the timer block.
// Constants live in timer16_regs.svh.
package timer16_pkg;

  typedef enum logic [3:0] {
    WGM_NORMAL = 4'h0,
    WGM_PC8 = 4'h1,
    WGM_PC9 = 4'h2,
    WGM_PC10 = 4'h3,
    WGM_CTC_OCR = 4'h4,
    WGM_FAST8 = 4'h5,
    WGM_FAST9 = 4'h6,
    WGM_FAST10 = 4'h7,
    WGM_PFC_ICR = 4'h8,
    WGM_PFC_OCR = 4'h9,
    WGM_PC_ICR = 4'hA,
    WGM_PC_OCR = 4'hB,
    WGM_CTC_ICR = 4'hC,
    WGM_RESERVED = 4'hD,
    WGM_FAST_ICR = 4'hE,
    WGM_FAST_OCR = 4'hF
  } waveform_mode_e;

  // Waveform family derived from the mode
  typedef enum logic [1:0] {
    FAM_NONPWM = 2'h0,
    FAM_FAST = 2'h1,
    FAM_DUAL = 2'h3
  } family_e;

endpackage

/* File: design/timer16_regs.svh */
// Register offsets, field positions, reset values and fixed TOP values of the timer.
// Included by the prescaler, the top design file and the bench; definitions only.
`ifndef TIMER16_REGS_SVH
`define TIMER16_REGS_SVH

// Avalon word addresses (byte address = 4 * index)
`define ADDR_CTRL_A 3'h0
`define ADDR_CTRL_B 3'h1
`define ADDR_COUNT 3'h2
`define ADDR_CMP_A 3'h3
`define ADDR_CMP_B 3'h4
`define ADDR_CAPTURE 3'h5
`define ADDR_IRQ_STATUS 3'h6
`define ADDR_IRQ_MASK 3'h7

// Control A fields
`define CA_MODE_A_HI 7
`define CA_MODE_A_LO 6
`define CA_MODE_B_HI 5
`define CA_MODE_B_LO 4
`define CA_WRITE_MASK 8'hF3
// Control B fields
`define CB_WGM_HI 4
`define CB_WGM_LO 3
`define CB_WRITE_MASK 8'h1F
`define CTRL_RESET 8'h00

// Status bits
`define ST_OVF 0
`define ST_CMPA 1
`define ST_CMPB 2
`define ST_WIDTH 3

// Counter values
`define TOP_8BIT 16'h00FF
`define TOP_9BIT 16'h01FF
`define TOP_10BIT 16'h03FF
`define COUNT_MAX 16'hFFFF
`define COUNT_BOTTOM 16'h0000

// Prescale divisors
`define PRESCALE_WIDTH 10
`define DIV_8 10'h007
`define DIV_64 10'h03F
`define DIV_256 10'h0FF
`define DIV_1024 10'h3FF

`endif

/* File: design/timer16_waveform_mode_control.sv */
// 16-bit timer/counter with waveform modes, two compare outputs and an Avalon-MM slave.
// Assumes a single 40 MHz clock; all inputs synchronous to clk_in.
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`include "timer16_regs.svh"

// Summary of operation
// - Everything runs on clk_in; timer tick is a one-cycle enable for count and flags.
// - Phase-and-frequency modes load compares and set overflow at BOTTOM.
// - Control A: A mode 7:6, B mode 5:4, zeros 3:2, low mode bits 1:0.
// - Output modes 10, 11 and a permitted 01 toggle override the pin; drive only when port direction is output.
// - Non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM 01 toggles channel A only in modes 14, 15; B disconnected.
// - Fast PWM 10 clears on match, sets at TOP; 11 the reverse.
// - Fast PWM with compare equal TOP: skip match, only the TOP action.
// - Dual-slope 01 toggles channel A only in modes 8 to 11.
// - Dual-slope 10 clears on up match, sets on down match; 11 opposite.
// - Four-bit mode from two low bits plus two bits of control B.
// - Modes 1-3 phase correct, 5-7 fast, fixed TOPs, load at TOP.
// - Mode 0 to 0xFFFF, modes 4, 12 clear at TOP, immediate load.
// - Modes 8, 9 load at BOTTOM; 10, 11 at TOP; 14, 15 fast; 13 reserved.
// - Upper mode bits at control B bits 4:3 beside clock select.
// - Clock select: stop, divide 1/8/64/256/1024, external falling or rising.
module timer16_waveform_mode_control (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Avalon-MM slave
  input wire logic [2:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // External count pin
  input wire logic ext_count_pin_in,
  // Port direction bits for the two compare pins
  input wire logic chan_a_port_dir_in,
  input wire logic chan_b_port_dir_in,
  // Compare outputs
  output logic chan_a_compare_output_out,
  output logic chan_a_pin_override_out,
  output logic chan_a_pin_oe_out,
  output logic chan_b_compare_output_out,
  output logic chan_b_pin_override_out,
  output logic chan_b_pin_oe_out,
  // Interrupt
  output logic irq_out
);

  logic [7:0] waveform_output_control_a_reg;
  logic [7:0] timer_control_b_reg;
  logic [15:0] counter_value_reg;
  logic [15:0] chan_a_compare_value_reg;
  logic [15:0] chan_b_compare_value_reg;
  logic [15:0] chan_a_buffer_reg;
  logic [15:0] chan_b_buffer_reg;
  logic [15:0] capture_value_reg;
  logic [2:0] irq_status_reg;
  logic [2:0] irq_mask_reg;
  logic count_up_reg;
  logic ack_reg;
  logic [31:0] readdata_reg;
  logic irq_reg;

  logic [3:0] waveform_mode_select;
  logic [1:0] family;
  logic [15:0] top_value;
  logic at_top;
  logic at_bottom;
  logic load_at_bottom;
  logic load_immediate;
  logic ovf_at_bottom;
  logic ovf_at_top;
  logic tick;
  logic wr_en;
  logic count_write;
  logic [15:0] counter_next;
  logic count_up_next;
  logic [2:0] event_set;
  logic match_a;
  logic match_b;

  // Mode decode
  assign waveform_mode_select = {timer_control_b_reg[`CB_WGM_HI:`CB_WGM_LO],
                                 waveform_output_control_a_reg[1:0]};

  always_comb begin
    top_value = `COUNT_MAX;
    family = timer16_pkg::FAM_NONPWM;
    load_immediate = 1'b0;
    load_at_bottom = 1'b0;
    ovf_at_bottom = 1'b0;
    ovf_at_top = 1'b0;
    unique case (waveform_mode_select)
      timer16_pkg::WGM_NORMAL: load_immediate = 1'b1;
      timer16_pkg::WGM_CTC_OCR: begin
        top_value = chan_a_compare_value_reg;
        load_immediate = 1'b1;
      end
      timer16_pkg::WGM_CTC_ICR: begin
        top_value = capture_value_reg;
        load_immediate = 1'b1;
      end
      timer16_pkg::WGM_PC8, timer16_pkg::WGM_PC9, timer16_pkg::WGM_PC10: begin
        family = timer16_pkg::FAM_DUAL;
        ovf_at_bottom = 1'b1;
        top_value = (waveform_mode_select[1:0] == 2'h1) ? `TOP_8BIT :
                    (waveform_mode_select[1:0] == 2'h2) ? `TOP_9BIT : `TOP_10BIT;
      end
      timer16_pkg::WGM_FAST8, timer16_pkg::WGM_FAST9, timer16_pkg::WGM_FAST10: begin
        family = timer16_pkg::FAM_FAST;
        ovf_at_top = 1'b1;
        top_value = (waveform_mode_select[1:0] == 2'h1) ? `TOP_8BIT :
                    (waveform_mode_select[1:0] == 2'h2) ? `TOP_9BIT : `TOP_10BIT;
      end
      timer16_pkg::WGM_PFC_ICR, timer16_pkg::WGM_PFC_OCR: begin
        family = timer16_pkg::FAM_DUAL;
        load_at_bottom = 1'b1;
        ovf_at_bottom = 1'b1;
        top_value = waveform_mode_select[0] ? chan_a_compare_value_reg : capture_value_reg;
      end
      timer16_pkg::WGM_PC_ICR, timer16_pkg::WGM_PC_OCR: begin
        family = timer16_pkg::FAM_DUAL;
        ovf_at_bottom = 1'b1;
        top_value = waveform_mode_select[0] ? chan_a_compare_value_reg : capture_value_reg;
      end
      timer16_pkg::WGM_FAST_ICR, timer16_pkg::WGM_FAST_OCR: begin
        family = timer16_pkg::FAM_FAST;
        ovf_at_top = 1'b1;
        top_value = waveform_mode_select[0] ? chan_a_compare_value_reg : capture_value_reg;
      end
      // Reserved mode runs as normal counting with compare outputs acting non-PWM
      timer16_pkg::WGM_RESERVED: load_immediate = 1'b1;
    endcase
  end

  assign at_top = (counter_value_reg == top_value);
  assign at_bottom = (counter_value_reg == `COUNT_BOTTOM);

  tick_prescaler u_tick (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .clock_source_select_in(timer_control_b_reg[2:0]),
    .ext_count_pin_in(ext_count_pin_in),
    .timer_tick_enable_out(tick)
  );

  // Bus: one wait cycle; a write lands on the edge that sees waitrequest low
  assign wr_en = avs_write_in & ack_reg;
  assign count_write = wr_en && (avs_address_in == `ADDR_COUNT);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read_in | avs_write_in) & ~ack_reg;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      waveform_output_control_a_reg <= `CTRL_RESET;
      timer_control_b_reg <= `CTRL_RESET;
      capture_value_reg <= `COUNT_BOTTOM;
      irq_mask_reg <= '0;
    end else if (wr_en) begin
      unique case (avs_address_in)
        `ADDR_CTRL_A: waveform_output_control_a_reg <=
            avs_writedata_in[7:0] & `CA_WRITE_MASK;
        `ADDR_CTRL_B: timer_control_b_reg <= avs_writedata_in[7:0] & `CB_WRITE_MASK;
        `ADDR_CAPTURE: capture_value_reg <= avs_writedata_in[15:0];
        `ADDR_IRQ_MASK: irq_mask_reg <= avs_writedata_in[`ST_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  // Buffered compare values and their load points
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      chan_a_buffer_reg <= `COUNT_BOTTOM;
      chan_b_buffer_reg <= `COUNT_BOTTOM;
    end else if (wr_en && avs_address_in == `ADDR_CMP_A) begin
      chan_a_buffer_reg <= avs_writedata_in[15:0];
    end else if (wr_en && avs_address_in == `ADDR_CMP_B) begin
      chan_b_buffer_reg <= avs_writedata_in[15:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      chan_a_compare_value_reg <= `COUNT_BOTTOM;
      chan_b_compare_value_reg <= `COUNT_BOTTOM;
    end else if (load_immediate) begin
      chan_a_compare_value_reg <= chan_a_buffer_reg;
      chan_b_compare_value_reg <= chan_b_buffer_reg;
    end else if (tick && (load_at_bottom ? at_bottom : at_top)) begin
      chan_a_compare_value_reg <= chan_a_buffer_reg;
      chan_b_compare_value_reg <= chan_b_buffer_reg;
    end
  end

  // Counter sequence
  always_comb begin
    counter_next = counter_value_reg;
    count_up_next = count_up_reg;
    if (family == timer16_pkg::FAM_DUAL) begin
      if (at_top) begin
        count_up_next = 1'b0;
        counter_next = counter_value_reg - 16'h0001;
      end else if (at_bottom) begin
        count_up_next = 1'b1;
        counter_next = 16'h0001;
      end else begin
        counter_next = count_up_reg ? counter_value_reg + 16'h0001
                                    : counter_value_reg - 16'h0001;
      end
    end else begin
      count_up_next = 1'b1;
      counter_next = at_top ? `COUNT_BOTTOM : counter_value_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      counter_value_reg <= `COUNT_BOTTOM;
      count_up_reg <= 1'b1;
    end else if (count_write) begin
      counter_value_reg <= avs_writedata_in[15:0];
    end else if (tick) begin
      counter_value_reg <= counter_next;
      count_up_reg <= count_up_next;
    end
  end

  // Matches qualified by the tick; a counter write blocks them this cycle
  assign match_a = tick && !count_write && (counter_value_reg == chan_a_compare_value_reg);
  assign match_b = tick && !count_write && (counter_value_reg == chan_b_compare_value_reg);

  always_comb begin
    event_set = '0;
    event_set[`ST_CMPA] = match_a;
    event_set[`ST_CMPB] = match_b;
    event_set[`ST_OVF] = tick && ((ovf_at_top && at_top)
                         || (ovf_at_bottom && at_bottom && !count_up_reg)
                         || (!ovf_at_top && !ovf_at_bottom && counter_value_reg == `COUNT_MAX));
  end

  // Sticky status; a new event wins over a write-one-to-clear
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_status_reg <= '0;
    end else if (wr_en && avs_address_in == `ADDR_IRQ_STATUS) begin
      irq_status_reg <= (irq_status_reg & ~avs_writedata_in[`ST_WIDTH-1:0]) | event_set;
    end else begin
      irq_status_reg <= irq_status_reg | event_set;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_status_reg & irq_mask_reg);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      readdata_reg <= '0;
    end else if (avs_read_in && !ack_reg) begin
      unique case (avs_address_in)
        `ADDR_CTRL_A: readdata_reg <= {24'h0, waveform_output_control_a_reg};
        `ADDR_CTRL_B: readdata_reg <= {24'h0, timer_control_b_reg};
        `ADDR_COUNT: readdata_reg <= {16'h0, counter_value_reg};
        `ADDR_CMP_A: readdata_reg <= {16'h0, chan_a_buffer_reg};
        `ADDR_CMP_B: readdata_reg <= {16'h0, chan_b_buffer_reg};
        `ADDR_CAPTURE: readdata_reg <= {16'h0, capture_value_reg};
        `ADDR_IRQ_STATUS: readdata_reg <= {29'h0, irq_status_reg};
        `ADDR_IRQ_MASK: readdata_reg <= {29'h0, irq_mask_reg};
      endcase
    end
  end

  assign avs_readdata_out = readdata_reg;
  assign avs_waitrequest_out = ~ack_reg;
  assign irq_out = irq_reg;

  // Pin-side outputs come from the channel waveform flops and registered config
  logic a_ovr;
  logic a_oe;
  logic b_ovr;
  logic b_oe;
  logic [3:0] pin_reg;

  compare_output_unit #(.IS_CHAN_A(1'b1)) u_chan_a (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .output_mode_in(waveform_output_control_a_reg[`CA_MODE_A_HI:`CA_MODE_A_LO]),
    .waveform_mode_select_in(waveform_mode_select),
    .family_in(family),
    .port_dir_out_in(chan_a_port_dir_in),
    .match_in(match_a),
    .at_top_in(tick && at_top),
    .counting_up_in(count_up_reg),
    .cmp_equals_top_in(chan_a_compare_value_reg == top_value),
    .compare_output_out(chan_a_compare_output_out),
    .pin_override_out(a_ovr),
    .pin_oe_out(a_oe)
  );

  compare_output_unit #(.IS_CHAN_A(1'b0)) u_chan_b (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .output_mode_in(waveform_output_control_a_reg[`CA_MODE_B_HI:`CA_MODE_B_LO]),
    .waveform_mode_select_in(waveform_mode_select),
    .family_in(family),
    .port_dir_out_in(chan_b_port_dir_in),
    .match_in(match_b),
    .at_top_in(tick && at_top),
    .counting_up_in(count_up_reg),
    .cmp_equals_top_in(chan_b_compare_value_reg == top_value),
    .compare_output_out(chan_b_compare_output_out),
    .pin_override_out(b_ovr),
    .pin_oe_out(b_oe)
  );

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_reg <= '0;
    end else begin
      pin_reg <= {a_ovr, a_oe, b_ovr, b_oe};
    end
  end

  assign chan_a_pin_override_out = pin_reg[3];
  assign chan_a_pin_oe_out = pin_reg[2];
  assign chan_b_pin_override_out = pin_reg[1];
  assign chan_b_pin_oe_out = pin_reg[0];
endmodule

/* File: sim/pin_load_model.sv */
// External load on one compare pin: a pulled-up pad.
// Assumes output enable and level come straight from the timer's pin ports.
`timescale 1ns/1ps

module pin_load_model #(
  parameter bit PULL = 1'b1
) (
  // Pad side
  input wire logic oe_in,
  input wire logic value_in,
  // Level seen by the load
  output logic pin_out
);
  // Released pad rests at the pull level, never the last driven value
  assign pin_out = oe_in ? value_in : PULL;
endmodule

/* File: sim/timer16_waveform_mode_control_checker.sv */
// Concurrent checks on the timer's bus handshake, pin enables and interrupt.
// Assumes a bind onto the top module; sees its ports only.
`timescale 1ns/1ps

module timer16_waveform_mode_control_checker (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic chan_a_port_dir_in,
  input wire logic chan_b_port_dir_in,
  input wire logic chan_a_pin_override_out,
  input wire logic chan_a_pin_oe_out,
  input wire logic chan_b_pin_override_out,
  input wire logic chan_b_pin_oe_out,
  input wire logic irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_take;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_ack;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence

  property p_handshake;
    s_take |=> s_ack;
  endproperty
  a_handshake: assert property (p_handshake)
    else $error("request not answered in one cycle");
  property p_ack_cause;
    !avs_waitrequest_out |-> $past(avs_read_in || avs_write_in);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("answer without request");
  property p_idle;
    !(avs_read_in || avs_write_in) && avs_waitrequest_out |=> avs_waitrequest_out;
  endproperty
  a_idle: assert property (p_idle)
    else $error("waitrequest dropped while idle");
  property p_wait_one;
    !avs_waitrequest_out |=> avs_waitrequest_out;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest low longer than one cycle");
  property p_rd_hold;
    $changed(avs_readdata_out) |-> $past(avs_read_in && avs_waitrequest_out);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without a read");
  property p_oe_a;
    chan_a_pin_oe_out == (chan_a_pin_override_out && $past(chan_a_port_dir_in));
  endproperty
  a_oe_a: assert property (p_oe_a)
    else $error("channel A pin enable wrong");
  property p_oe_b;
    chan_b_pin_oe_out == (chan_b_pin_override_out && $past(chan_b_port_dir_in));
  endproperty
  a_oe_b: assert property (p_oe_b)
    else $error("channel B pin enable wrong");
  property p_irq_fall;
    $fell(irq_out) |-> $past(avs_write_in, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt fell without a register write");
endmodule

bind timer16_waveform_mode_control timer16_waveform_mode_control_checker
  timer16_waveform_mode_control_checker_inst (.clk_in, .rst_n_in, .avs_read_in, .avs_write_in,
  .avs_readdata_out, .avs_waitrequest_out, .chan_a_port_dir_in, .chan_b_port_dir_in,
  .chan_a_pin_override_out, .chan_a_pin_oe_out, .chan_b_pin_override_out,
  .chan_b_pin_oe_out, .irq_out);

/* File: sim/timer16_waveform_mode_control_tb.sv */
// Self-checking bench for the timer: registers, waveform modes, pins, interrupt.
// Assumes the design files and the bound checker are compiled first.
`timescale 1ns/1ps
`include "timer16_regs.svh"

module timer16_waveform_mode_control_tb;
  logic clk_in, rst_n_in, avs_read_in, avs_write_in, ext_count_pin_in;
  logic chan_a_port_dir_in, chan_b_port_dir_in, avs_waitrequest_out, irq_out;
  logic [2:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, rdat, stat;
  logic chan_a_compare_output_out, chan_a_pin_override_out, chan_a_pin_oe_out;
  logic chan_b_compare_output_out, chan_b_pin_override_out, chan_b_pin_oe_out, lvl_a, lvl_b;
  logic [31:0] seed = 32'h36B39221;
  int n_mismatch = 0;
  int n_compared = 0;

  timer16_waveform_mode_control timer16_waveform_mode_control_inst (.clk_in, .rst_n_in,
    .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_readdata_out,
    .avs_waitrequest_out, .ext_count_pin_in, .chan_a_port_dir_in, .chan_b_port_dir_in,
    .chan_a_compare_output_out, .chan_a_pin_override_out, .chan_a_pin_oe_out,
    .chan_b_compare_output_out, .chan_b_pin_override_out, .chan_b_pin_oe_out, .irq_out);
  pin_load_model pin_load_model_a (.oe_in(chan_a_pin_oe_out),
    .value_in(chan_a_compare_output_out), .pin_out(lvl_a));
  pin_load_model pin_load_model_b (.oe_in(chan_b_pin_oe_out),
    .value_in(chan_b_compare_output_out), .pin_out(lvl_b));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task check(input string w, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", w, e, s);
    end
  endtask

  task test_done();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    @(posedge clk_in);
    while (avs_waitrequest_out !== 1'b0 && k < 20) begin
      @(posedge clk_in);
      k++;
    end
    if (k == 20)
      n_mismatch++;
    rdat = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge clk_in);
  endtask

  // Compares loaded in mode 0 first, so buffered modes start with known values
  task automatic leg(input logic [3:0] md, input logic [1:0] cm, input logic [15:0] cmp,
                     input logic [15:0] st, input int cyc);
    logic [31:0] r;
    r = xs();
    chan_a_port_dir_in <= r[0];
    chan_b_port_dir_in <= r[1];
    bus(1'b1, `ADDR_CTRL_B, 32'h0);
    bus(1'b1, `ADDR_CTRL_A, 32'h0);
    bus(1'b1, `ADDR_CMP_A, {16'h0, cmp});
    bus(1'b1, `ADDR_CMP_B, {16'h0, cmp});
    bus(1'b1, `ADDR_COUNT, {16'h0, st});
    bus(1'b1, `ADDR_IRQ_STATUS, 32'h7);
    bus(1'b1, `ADDR_CTRL_A, {24'h0, cm, cm, 2'b00, md[1:0]});
    bus(1'b1, `ADDR_CTRL_B, {27'h0, md[3:2], 3'b001});
    repeat (cyc) @(posedge clk_in);
    bus(1'b1, `ADDR_CTRL_B, {27'h0, md[3:2], 3'b000});
    bus(1'b0, `ADDR_IRQ_STATUS, 32'h0);
    stat = rdat;
  endtask

  task outs(input logic e);
    check("out_a", chan_a_compare_output_out, e);
    check("out_b", chan_b_compare_output_out, e);
    check("lvl_a", lvl_a, chan_a_port_dir_in ? e : 1'b1);
    check("lvl_b", lvl_b, chan_b_port_dir_in ? e : 1'b1);
  endtask

  task pins(input logic oa, input logic ob);
    check("ovr_a", chan_a_pin_override_out, oa);
    check("oe_a", chan_a_pin_oe_out, oa & chan_a_port_dir_in);
    check("ovr_b", chan_b_pin_override_out, ob);
    check("oe_b", chan_b_pin_oe_out, ob & chan_b_port_dir_in);
  endtask

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  initial begin
    repeat (30000) @(posedge clk_in);
    n_mismatch++;
    test_done();
  end

  initial begin
    {rst_n_in, avs_read_in, avs_write_in, ext_count_pin_in} = 4'h0;
    {chan_a_port_dir_in, chan_b_port_dir_in, avs_address_in} = 5'h0;
    avs_writedata_in = 32'h0;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    bus(1'b0, `ADDR_CTRL_A, 32'h0);
    check("ctrl_a", rdat, 32'h0);
    bus(1'b1, `ADDR_CTRL_A, 32'hFF);
    bus(1'b0, `ADDR_CTRL_A, 32'h0);
    check("ctrl_a", rdat, 32'hF3);
    bus(1'b1, `ADDR_CTRL_B, 32'hFF);
    bus(1'b0, `ADDR_CTRL_B, 32'h0);
    check("ctrl_b", rdat, 32'h1F);
    leg(4'h0, 2'b11, 16'h0020, 16'h0000, 60);
    outs(1'b1);
    check("cmp_flag", stat[`ST_CMPA], 1'b1);
    pins(1'b1, 1'b1);
    leg(4'h0, 2'b10, 16'h0020, 16'h0000, 60);
    outs(1'b0);
    leg(4'h0, 2'b01, 16'h0020, 16'h0000, 60);
    outs(1'b1);
    leg(4'h4, 2'b01, 16'h0020, 16'h0000, 50);
    outs(1'b0);
    bus(1'b0, `ADDR_COUNT, 32'h0);
    check("ctc_wrap", rdat < 32'h20, 1'b1);
    leg(4'h0, 2'b00, 16'h8000, 16'hFFF0, 40);
    check("ovf_max", stat[`ST_OVF], 1'b1);
    pins(1'b0, 1'b0);
    bus(1'b1, `ADDR_IRQ_MASK, 32'h6);
    @(posedge clk_in);
    check("irq_masked", irq_out, 1'b0);
    bus(1'b1, `ADDR_IRQ_MASK, 32'h1);
    @(posedge clk_in);
    check("irq_on", irq_out, 1'b1);
    bus(1'b1, `ADDR_IRQ_STATUS, 32'h1);
    @(posedge clk_in);
    check("irq_clr", irq_out, 1'b0);
    for (int c = 2; c < 4; c++) begin
      leg(4'h5, c[1:0], 16'h0010, 16'h0000, 60);
      outs(c[0]);
      leg(4'h5, c[1:0], 16'h0010, 16'h00F0, 20);
      outs(!c[0]);
      check("ovf_top", stat[`ST_OVF], 1'b1);
      leg(4'h1, c[1:0], 16'h0080, 16'h00F0, 160);
      outs(!c[0]);
      leg(4'h1, c[1:0], 16'h0080, 16'h0001, 200);
      outs(c[0]);
    end
    leg(4'h5, 2'b10, 16'h00FF, 16'h00F0, 20);
    outs(1'b1);
    bus(1'b1, `ADDR_CAPTURE, 32'hFF);
    leg(4'h8, 2'b10, 16'h0080, 16'h00F0, 160);
    outs(1'b1);
    leg(4'h8, 2'b10, 16'h0080, 16'h0001, 200);
    check("ovf_bottom", stat[`ST_OVF], 1'b1);
    bus(1'b1, `ADDR_COUNT, 32'h0);
    bus(1'b1, `ADDR_CTRL_B, 32'h2);
    repeat (80) @(posedge clk_in);
    bus(1'b1, `ADDR_CTRL_B, 32'h0);
    bus(1'b0, `ADDR_COUNT, 32'h0);
    check("div8", rdat >= 32'h9 && rdat <= 32'hB, 1'b1);
    bus(1'b1, `ADDR_COUNT, 32'h0);
    bus(1'b1, `ADDR_CTRL_B, 32'h7);
    repeat (12) begin
      ext_count_pin_in <= !ext_count_pin_in;
      @(posedge clk_in);
    end
    bus(1'b1, `ADDR_CTRL_B, 32'h0);
    bus(1'b0, `ADDR_COUNT, 32'h0);
    check("ext_rise", rdat, 32'h6);
    for (int m = 0; m < 16; m++) begin
      bus(1'b1, `ADDR_CTRL_B, {27'h0, m[3:2], 3'b000});
      bus(1'b1, `ADDR_CTRL_A, {24'h0, 4'h5, 2'b00, m[1:0]});
      bus(1'b0, `ADDR_CTRL_B, 32'h0);
      check("mode_hi", rdat, {27'h0, m[3:2], 3'b000});
      pins(m inside {0, 4, 12, 13} || m >= 8, m inside {0, 4, 12, 13});
    end
    test_done();
  end
endmodule
